/* core/sample_to_output_lane_latency.sv */
// Sample routing onto primary and delayed output buses with fixed latency
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sample_to_output_lane_latency
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Converter codes, rising and falling edge samples
  input wire logic [lane_latency_pkg::CODE_W-1:0] i_rise_code,
  input wire logic [lane_latency_pkg::CODE_W-1:0] i_fall_code,
  input wire logic [lane_latency_pkg::CODE_W-1:0] q_rise_code,
  input wire logic [lane_latency_pkg::CODE_W-1:0] q_fall_code,
  // Register port
  input wire logic [lane_latency_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lane_latency_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lane_latency_pkg::DATA_W-1:0] reg_rdata,
  // Output buses
  output logic [lane_latency_pkg::CODE_W-1:0] primary_i_bus,
  output logic [lane_latency_pkg::CODE_W-1:0] primary_q_bus,
  output logic [lane_latency_pkg::CODE_W-1:0] delayed_i_bus,
  output logic delayed_i_bus_oe,
  output logic [lane_latency_pkg::CODE_W-1:0] delayed_q_bus,
  output logic delayed_q_bus_oe,
  output logic out_valid
);

  // ==========================================================
  // Control register
  logic [lane_latency_pkg::CTRL_W-1:0] ctrl_ff;
  logic [lane_latency_pkg::CTRL_W-1:0] nxt_ctrl;
  logic ctrl_wr;
  logic status_rd;
  logic ctrl_rd;

  assign ctrl_wr = reg_wr && (reg_addr == lane_latency_pkg::CTRL_OFS);
  assign ctrl_rd = reg_rd && (reg_addr == lane_latency_pkg::CTRL_OFS);
  assign status_rd = reg_rd && (reg_addr == lane_latency_pkg::STATUS_OFS);
  assign nxt_ctrl = ctrl_wr ? reg_wdata[lane_latency_pkg::CTRL_W-1:0] : ctrl_ff;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_ff <= lane_latency_pkg::CTRL_RESET;
    else
      ctrl_ff <= nxt_ctrl;
  end

  // ==========================================================
  // Mode decode
  logic ecm_on;
  logic dual_on;
  logic demux_on;
  lane_latency_pkg::src_sel_type req_src;
  lane_latency_pkg::src_sel_type eff_src;
  logic src_refused;

  assign ecm_on = ctrl_ff[lane_latency_pkg::CTRL_ECM_BIT];
  // Two channels at base rate, or one channel on both edges
  assign dual_on = ctrl_ff[lane_latency_pkg::CTRL_DUAL_BIT];
  assign demux_on = ctrl_ff[lane_latency_pkg::CTRL_DEMUX_BIT];
  assign req_src = lane_latency_pkg::src_sel_type'(ctrl_ff[lane_latency_pkg::CTRL_SEL_LSB +: 2]);

  // Q or both inputs need extended control; otherwise I alone
  always_comb
  begin
    unique case (req_src)
      lane_latency_pkg::SRC_DEFAULT: eff_src = lane_latency_pkg::SRC_I;
      lane_latency_pkg::SRC_I: eff_src = lane_latency_pkg::SRC_I;
      lane_latency_pkg::SRC_Q: eff_src = ecm_on ? lane_latency_pkg::SRC_Q : lane_latency_pkg::SRC_I;
      lane_latency_pkg::SRC_BOTH: eff_src = ecm_on ? lane_latency_pkg::SRC_BOTH : lane_latency_pkg::SRC_I;
    endcase
  end

  assign src_refused = dual_on && (req_src != lane_latency_pkg::SRC_DEFAULT) && (eff_src != req_src);

  // ==========================================================
  // Converter routing: lane A takes rising-edge samples, lane B falling-edge ones in dual-edge mode and Q rising ones otherwise
  lane_if lane_a ();
  lane_if lane_b ();
  logic [lane_latency_pkg::CODE_W-1:0] a_sample;
  logic [lane_latency_pkg::CODE_W-1:0] b_sample;
  logic [lane_latency_pkg::CODE_W-1:0] dual_a_sample;
  logic [lane_latency_pkg::CODE_W-1:0] dual_b_sample;

  // Dual-edge: rising converter on I unless Q-only, falling on I unless Q or both
  assign dual_a_sample = (eff_src == lane_latency_pkg::SRC_Q) ? q_rise_code : i_rise_code;
  assign dual_b_sample = (eff_src == lane_latency_pkg::SRC_I) ? i_fall_code : q_fall_code;
  // Single-edge takes only rising samples, one per period per channel
  assign a_sample = dual_on ? dual_a_sample : i_rise_code;
  assign b_sample = dual_on ? dual_b_sample : q_rise_code;

  // Every cycle a new code enters, no start needed
  assign lane_a.sample = a_sample;
  assign lane_b.sample = b_sample;

  sample_delay_line line_a
  (
    .core_clk (core_clk),
    .reset_n (reset_n),
    .lane (lane_a.line)
  );

  sample_delay_line line_b
  (
    .core_clk (core_clk),
    .reset_n (reset_n),
    .lane (lane_b.line)
  );

  // ==========================================================
  // Output buses
  logic [lane_latency_pkg::CODE_W-1:0] primary_i_ff;
  logic [lane_latency_pkg::CODE_W-1:0] primary_q_ff;
  logic [lane_latency_pkg::CODE_W-1:0] delayed_i_ff;
  logic [lane_latency_pkg::CODE_W-1:0] delayed_q_ff;
  logic delayed_oe_ff;
  logic [lane_latency_pkg::CODE_W-1:0] nxt_delayed_i;
  logic [lane_latency_pkg::CODE_W-1:0] nxt_delayed_q;

  // Delayed buses idle low while not driven
  assign nxt_delayed_i = demux_on ? lane_a.tap_delayed : '0;
  assign nxt_delayed_q = demux_on ? lane_b.tap_delayed : '0;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      primary_i_ff <= '0;
      primary_q_ff <= '0;
      delayed_i_ff <= '0;
      delayed_q_ff <= '0;
      delayed_oe_ff <= 1'b0;
    end
    else
    begin
      primary_i_ff <= lane_a.tap_primary;
      primary_q_ff <= lane_b.tap_primary;
      delayed_i_ff <= nxt_delayed_i;
      delayed_q_ff <= nxt_delayed_q;
      delayed_oe_ff <= demux_on;
    end
  end

  assign primary_i_bus = primary_i_ff;
  assign primary_q_bus = primary_q_ff;
  assign delayed_i_bus = delayed_i_ff;
  assign delayed_q_bus = delayed_q_ff;
  assign delayed_i_bus_oe = delayed_oe_ff;
  assign delayed_q_bus_oe = delayed_oe_ff;

  // ==========================================================
  // Pipeline fill tracking; a control write restarts it
  logic [lane_latency_pkg::FILL_W-1:0] fill_ff;
  logic [lane_latency_pkg::FILL_W-1:0] nxt_fill;
  logic fill_done;

  assign fill_done = (fill_ff == lane_latency_pkg::FILL_DONE_CNT);
  assign nxt_fill = ctrl_wr ? '0 : (fill_done ? fill_ff : fill_ff + lane_latency_pkg::FILL_STEP);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      fill_ff <= '0;
    else
      fill_ff <= nxt_fill;
  end

  assign out_valid = fill_done;

  // ==========================================================
  // Read data, present only in the cycle after the read strobe
  logic [lane_latency_pkg::DATA_W-1:0] status_word;
  logic [lane_latency_pkg::DATA_W-1:0] ctrl_word;
  logic [lane_latency_pkg::DATA_W-1:0] rd_mux;
  logic [lane_latency_pkg::DATA_W-1:0] rdata_ff;

  always_comb
  begin
    status_word = '0;
    status_word[lane_latency_pkg::STAT_VALID_BIT] = fill_done;
    status_word[lane_latency_pkg::STAT_DUAL_BIT] = dual_on;
    status_word[lane_latency_pkg::STAT_DEMUX_BIT] = demux_on;
    status_word[lane_latency_pkg::STAT_SRC_LSB +: 2] = eff_src;
    status_word[lane_latency_pkg::STAT_REFUSED_BIT] = src_refused;
  end

  assign ctrl_word = {{(lane_latency_pkg::DATA_W-lane_latency_pkg::CTRL_W){1'b0}}, ctrl_ff};
  assign rd_mux = ctrl_rd ? ctrl_word : (status_rd ? status_word : '0);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_ff <= '0;
    else
      rdata_ff <= rd_mux;
  end

  assign reg_rdata = rdata_ff;

  // ==========================================================
  // Checks
  sequence cfg_write_seq;
    ctrl_wr;
  endsequence

  sequence refill_seq;
    (fill_ff == '0) ##1 !fill_done;
  endsequence

  chk_fill_restart: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cfg_write_seq |=> refill_seq)
    else $error("pipeline fill did not restart after control write");

  chk_valid_holds: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && !ctrl_wr |=> fill_done)
    else $error("output valid dropped without control write");

  chk_primary_i_lat: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && !dual_on |-> primary_i_bus == $past(i_rise_code, 34))
    else $error("primary I bus not 34 cycles after rising sample");

  chk_single_q_lat: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && !dual_on |-> primary_q_bus == $past(q_rise_code, 34))
    else $error("primary Q bus not 34 cycles after rising sample");

  chk_delayed_i_lat: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && demux_on && eff_src != lane_latency_pkg::SRC_Q |-> delayed_i_bus == $past(i_rise_code, 35))
    else $error("delayed I bus not 35 cycles after rising sample");

  chk_dual_fall_q: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && dual_on && demux_on && eff_src == lane_latency_pkg::SRC_I
    |-> primary_q_bus == $past(i_fall_code, 34) && delayed_q_bus == $past(i_fall_code, 35))
    else $error("dual-edge Q buses not carrying falling samples");

  chk_undriven_delayed: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !demux_on ##1 !demux_on |-> !delayed_i_bus_oe && !delayed_q_bus_oe && delayed_i_bus == '0)
    else $error("delayed buses driven in non-demux operation");

  chk_pin_source_i: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !ecm_on |-> eff_src == lane_latency_pkg::SRC_I && !(dual_on && primary_i_bus != $past(i_rise_code, 34) && fill_done))
    else $error("Q source selected without extended control");

  chk_default_source: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    dual_on && req_src == lane_latency_pkg::SRC_DEFAULT && fill_done
    |-> primary_i_bus == $past(i_rise_code, 34) && primary_q_bus == $past(i_fall_code, 34))
    else $error("default dual-edge source is not the I input");

  chk_q_only: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    dual_on && eff_src == lane_latency_pkg::SRC_Q && fill_done
    |-> primary_i_bus == $past(q_rise_code, 34) && primary_q_bus == $past(q_fall_code, 34))
    else $error("Q-only setting not sampling the Q input");

  chk_both_inputs: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    dual_on && eff_src == lane_latency_pkg::SRC_BOTH && fill_done
    |-> primary_i_bus == $past(i_rise_code, 34) && primary_q_bus == $past(q_fall_code, 34))
    else $error("both-inputs setting not sampling each own input");

  chk_read_one_cycle: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    status_rd |=> reg_rdata[lane_latency_pkg::STAT_DUAL_BIT] == $past(dual_on) ##1 (reg_rdata == '0 || $past(reg_rd)))
    else $error("status read data wrong or held too long");

  // ==========================================================
  // Further checks on routing, enables and fill
  sequence fill_run_seq;
    !fill_done [*8];
  endsequence

  chk_fill_stays_low: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cfg_write_seq |=> fill_run_seq)
    else $error("output valid rose too soon after control write");

  chk_bus_gap: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && demux_on |-> delayed_i_bus == $past(primary_i_bus))
    else $error("delayed I bus not one cycle behind primary I bus");

  chk_delayed_q_lat: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && demux_on && !dual_on |-> delayed_q_bus == $past(q_rise_code, 35))
    else $error("delayed Q bus not 35 cycles after rising sample");

  chk_delayed_q_dual: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && dual_on && demux_on && eff_src != lane_latency_pkg::SRC_I
    |-> delayed_q_bus == $past(q_fall_code, 35))
    else $error("dual-edge delayed Q bus not carrying falling Q samples");

  chk_nondemux_q: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fill_done && !demux_on && dual_on && eff_src == lane_latency_pkg::SRC_Q
    |-> primary_q_bus == $past(q_fall_code, 34))
    else $error("non-demux dual-edge Q bus not carrying interleaved sample");

  chk_single_rise: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !dual_on |-> a_sample == i_rise_code && b_sample == q_rise_code)
    else $error("single-edge routing not taking rising samples");

  chk_dual_edges: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    dual_on && eff_src == lane_latency_pkg::SRC_I |-> a_sample == i_rise_code && b_sample == i_fall_code)
    else $error("dual-edge routing not taking both edges");

  chk_oe_on: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    demux_on |=> delayed_i_bus_oe && delayed_q_bus_oe)
    else $error("delayed buses not driven in demux operation");

  chk_oe_off: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !demux_on |=> !delayed_i_bus_oe && !delayed_q_bus_oe)
    else $error("delayed buses still driven after leaving demux operation");

  chk_ctrl_lands: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cfg_write_seq |=> ctrl_ff == $past(reg_wdata[lane_latency_pkg::CTRL_W-1:0]))
    else $error("control write did not land");

endmodule

/* core/lane_latency_pkg.sv */
// Constants and types for the sample-to-output lane latency block
package lane_latency_pkg;

  // ==========================================================
  // Data and bus widths
  localparam int CODE_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // Latencies in sampling clock cycles
  localparam int PRIMARY_LAT = 34;
  localparam int DELAYED_LAT = 35;
  localparam int LINE_DEPTH = DELAYED_LAT - 1;
  localparam int FILL_W = 6;
  localparam logic [FILL_W-1:0] FILL_DONE_CNT = FILL_W'(DELAYED_LAT);
  localparam logic [FILL_W-1:0] FILL_STEP = 6'h01;

  // ==========================================================
  // Register map
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;

  // Control fields
  localparam int CTRL_ECM_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam int CTRL_DEMUX_BIT = 2;
  localparam int CTRL_SEL_LSB = 3;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;

  // Status fields
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_DUAL_BIT = 1;
  localparam int STAT_DEMUX_BIT = 2;
  localparam int STAT_SRC_LSB = 3;
  localparam int STAT_REFUSED_BIT = 5;

  // ==========================================================
  // Input selection for dual-edge sampling
  typedef enum logic [1:0]
  {
    SRC_DEFAULT = 2'b00,
    SRC_I = 2'b01,
    SRC_Q = 2'b10,
    SRC_BOTH = 2'b11
  } src_sel_type;

endpackage

/* core/lane_if.sv */
// Interface joining the lane selector to one sample delay line
`timescale 1ns/1ps
interface lane_if;
  logic [lane_latency_pkg::CODE_W-1:0] sample;
  logic [lane_latency_pkg::CODE_W-1:0] tap_primary;
  logic [lane_latency_pkg::CODE_W-1:0] tap_delayed;

  modport feeder (output sample, input tap_primary, input tap_delayed);
  modport line (input sample, output tap_primary, output tap_delayed);
endinterface

/* core/sample_delay_line.sv */
// Fixed-length shift line delivering primary and delayed taps
`timescale 1ns/1ps
module sample_delay_line
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Lane
  lane_if.line lane
);

  logic [lane_latency_pkg::CODE_W-1:0] stage_ff [0:lane_latency_pkg::LINE_DEPTH-1];

  // ==========================================================
  // Shift stages
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      stage_ff[0] <= '0;
    else
      stage_ff[0] <= lane.sample;
  end

  genvar g;
  generate
    for (g = 1; g < lane_latency_pkg::LINE_DEPTH; g++)
    begin : gen_stage
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
          stage_ff[g] <= '0;
        else
          stage_ff[g] <= stage_ff[g-1];
      end
    end
  endgenerate

  // One output flop follows each tap in the top module
  assign lane.tap_primary = stage_ff[lane_latency_pkg::PRIMARY_LAT-2];
  assign lane.tap_delayed = stage_ff[lane_latency_pkg::DELAYED_LAT-2];

endmodule

/* verification/sample_capture.sv */
// Capture-side model that realigns primary and delayed buses
`timescale 1ns/1ps
module sample_capture
(
  // Clock
  input wire logic core_clk,
  // Buses from the converter
  input wire logic [lane_latency_pkg::CODE_W-1:0] primary_bus,
  input wire logic [lane_latency_pkg::CODE_W-1:0] delayed_bus,
  // Alignment result
  output logic pair_ok
);
  logic [lane_latency_pkg::CODE_W-1:0] prim_ff;

  // ==========================================================
  // Primary is one cycle ahead, hold it to meet its delayed twin
  always_ff @(posedge core_clk)
    prim_ff <= primary_bus;
  assign pair_ok = (prim_ff === delayed_bus);
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the lane latency block
`timescale 1ns/1ps
module tb_top;
  localparam int CW = lane_latency_pkg::CODE_W;
  logic core_clk;
  logic reset_n;
  logic [CW-1:0] i_rise_code;
  logic [CW-1:0] i_fall_code;
  logic [CW-1:0] q_rise_code;
  logic [CW-1:0] q_fall_code;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [CW-1:0] primary_i_bus;
  logic [CW-1:0] primary_q_bus;
  logic [CW-1:0] delayed_i_bus;
  logic [CW-1:0] delayed_q_bus;
  logic delayed_i_bus_oe;
  logic delayed_q_bus_oe;
  logic out_valid;
  logic pair_ok;
  wire [CW-1:0] delayed_i_wire = delayed_i_bus_oe ? delayed_i_bus : 'z;
  int cnt = 0;
  int cycles = 0;
  int n_mismatch = 0;
  int checks_done = 0;

  sample_to_output_lane_latency uut (.core_clk(core_clk), .reset_n(reset_n), .i_rise_code(i_rise_code),
    .i_fall_code(i_fall_code), .q_rise_code(q_rise_code), .q_fall_code(q_fall_code), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .primary_i_bus(primary_i_bus), .primary_q_bus(primary_q_bus), .delayed_i_bus(delayed_i_bus),
    .delayed_i_bus_oe(delayed_i_bus_oe), .delayed_q_bus(delayed_q_bus),
    .delayed_q_bus_oe(delayed_q_bus_oe), .out_valid(out_valid));
  sample_capture capture (.core_clk(core_clk), .primary_bus(primary_i_bus), .delayed_bus(delayed_i_wire),
    .pair_ok(pair_ok));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========================================================
  // Stimulus: distinct codes per input, stamped by cycle
  function automatic logic [CW-1:0] code(input int c, input int k);
    return CW'(c + k * 256);
  endfunction

  // Lane A (k=0/2) or lane B (k=2 single-edge, k=1/3 dual-edge) source for a mode
  function automatic logic [CW-1:0] lane(input int c, input logic b, input logic dual, input logic [1:0] src);
    if (!dual)
      return code(c, b ? 2 : 0);
    if (!b)
      return code(c, src == 2'b10 ? 2 : 0);
    return code(c, src == 2'b01 ? 1 : 3);
  endfunction

  initial
  begin
    i_rise_code = code(0, 0);
    i_fall_code = code(0, 1);
    q_rise_code = code(0, 2);
    q_fall_code = code(0, 3);
  end

  always @(posedge core_clk)
  begin
    cnt <= cnt + 1;
    i_rise_code <= code(cnt + 1, 0);
    i_fall_code <= code(cnt + 1, 1);
    q_rise_code <= code(cnt + 1, 2);
    q_fall_code <= code(cnt + 1, 3);
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      print_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (!ok)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    @(negedge core_clk);
    check(reg_rdata === 32'h0, "read data held too long");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    @(negedge core_clk);
    check(primary_i_bus === '0 && delayed_i_bus_oe === 1'b0 && out_valid === 1'b0, "outputs in reset");
    @(posedge core_clk);
    reset_n <= 1'b1;
    reg_read(8'h00, d);
    check(d === 32'h0000_0004, "control reset value");
    reg_write(8'h04, 32'hFFFF_FFFF);
    reg_write(8'h08, 32'hFFFF_FFFF);
    reg_read(8'h08, d);
    check(d === 32'h0, "unmapped read");
    reg_read(8'h00, d);
    check(d === 32'h0000_0004, "control after stray writes");
    repeat (40) @(negedge core_clk);
    reg_read(8'h04, d);
    check(d === 32'h0000_000D, "status after fill");
    check(delayed_i_bus_oe === 1'b1 && delayed_q_bus_oe === 1'b1, "delayed buses driven");
    $display("test done: reset");
  endtask

  task automatic t_mode(input logic [4:0] ctrl);
    logic dual;
    logic demux;
    logic refused;
    logic [1:0] src;
    logic [31:0] d;
    int k;
    dual = ctrl[1];
    demux = ctrl[2];
    src = (ctrl[4:3] == 2'b00 || !ctrl[0]) ? 2'b01 : ctrl[4:3];
    refused = dual && !ctrl[0] && ctrl[4];
    reg_write(8'h00, {27'h0, ctrl});
    repeat (2) @(negedge core_clk);
    check(out_valid === 1'b0, "fill restarts");
    k = 0;
    while (out_valid !== 1'b1 && k < 40)
    begin
      @(negedge core_clk);
      k++;
    end
    check(k === 34, "fill length");
    reg_read(8'h00, d);
    check(d === {27'h0, ctrl}, "control readback");
    reg_read(8'h04, d);
    check(d === {26'h0, refused, src, demux, dual, 1'b1}, "status fields");
    repeat (16)
    begin
      @(negedge core_clk);
      check(primary_i_bus === lane(cnt - 34, 1'b0, dual, src), "primary lane A");
      check(primary_q_bus === lane(cnt - 34, 1'b1, dual, src), "primary lane B");
      if (demux)
      begin
        check(delayed_i_bus === lane(cnt - 35, 1'b0, dual, src), "delayed lane A");
        check(delayed_q_bus === lane(cnt - 35, 1'b1, dual, src), "delayed lane B");
        check(delayed_i_bus_oe === 1'b1 && delayed_q_bus_oe === 1'b1, "delayed driven");
        check(pair_ok === 1'b1, "capture alignment");
      end
      else
      begin
        check(delayed_i_bus_oe === 1'b0 && delayed_q_bus_oe === 1'b0, "delayed released");
        check(delayed_i_bus === '0 && delayed_q_bus === '0, "delayed data idle");
      end
    end
    $display("test done: mode %h", ctrl);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_mode(5'h04);
    t_mode(5'h06);
    t_mode(5'h16);
    t_mode(5'h17);
    t_mode(5'h1F);
    t_mode(5'h0F);
    t_mode(5'h00);
    t_mode(5'h13);
    print_verdict();
  end
endmodule
